// ===== rtl/ghp_ctrl.sv
// Gauge housekeeping: resets, wake, flash gate, calibration, profiles
// Summary of operation
// - Count software resets per type, readable
// - Partial reset checks RAM sum, else full
// - Stored sum refreshed on every RAM write
// - Wake event on threshold crossing while asleep
// - Threshold from sense select and range bit
// - Sense select zero disables wake comparator
// - Flash write only at minimum cell voltage
// - Calibrate on sleep entry unless temperature extreme
// - Single calibration on voltage or temperature drift
// - Hold last current rate during calibration
// - Abort calibration on voltage drop over 32 mV
// - Subtract calibrated offset from sense voltage
// - Two default and two dynamic profiles
// - Single variant locks default selection
// - Battery good only after first OCV
// - Impedance from OCV, load voltage, current
// - Status byte: unsupported bit1, last profile bit0
// - Single variant seeds dynamic profiles, updates them
// - Match dynamic profile 0 then 1
// - No match overwrites least recently used
// - Auto sleep needs enable and low current
`timescale 1ns/10ps
`default_nettype none
module ghp_ctrl
    import ghp_pkg::*;
#(
    parameter int          RAM_WORDS      = 16,
    parameter bit          SINGLE_PROFILE = 1'b1,
    parameter logic [15:0] Z_TOL_MOHM     = 16'h0010,
    parameter logic [32:0] TDWELL_CYC     = 33'(CAL_TDWELL_CYC)
) (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_b,
    input  wire ghp_cfg_t                     cfg,
    input  wire ghp_meas_t                    meas,
    input  wire logic                         sw_reset_req,
    input  wire logic                         sw_reset_partial,
    input  wire logic                         ram_wr,
    input  wire logic                         ram_upset,
    input  wire logic [$clog2(RAM_WORDS)-1:0] ram_addr,
    input  wire logic [7:0]                   ram_wdata,
    output logic      [7:0]                   ram_rdata,
    output logic                              ram_busy,
    input  wire logic                         hibernate_in,
    output logic                              sleep_active,
    output logic                              wake_event,
    input  wire logic                         flash_wr_req,
    output logic                              flash_wr_go,
    output logic                              flash_wr_refused,
    input  wire logic signed [15:0]           cal_offset_uv,
    output logic                              cal_busy,
    output logic signed [15:0]                vsr_corr_uv,
    output logic signed [15:0]                current_hold_ma,
    input  wire logic                         batt_present_pin,
    input  wire logic                         ocv_soc_done,
    input  wire logic [15:0]                  ocv_mv,
    input  wire logic                         unsup_detect,
    input  wire logic                         def_sel,
    input  wire logic [15:0]                  def_z0_mohm,
    input  wire logic [15:0]                  def_z1_mohm,
    input  wire logic                         z_update_valid,
    input  wire logic [15:0]                  z_update_mohm,
    output logic                              battery_good_out,
    output logic                              profile_copy,
    output logic      [15:0]                  meas_z_mohm,
    input  wire logic                         cmd_valid,
    input  wire logic [7:0]                   cmd_code,
    output logic      [15:0]                  cmd_data,
    output logic                              cmd_ack
);
    localparam int AW = $clog2(RAM_WORDS);
    localparam logic [31:0] CAL_CYC = 32'(CAL_RUN_CYC);

    typedef enum logic [1:0] {CS_IDLE, CS_SCAN, CS_CHECK} ghp_cs_t;
    typedef enum logic [1:0] {PS_ABSENT, PS_OCV, PS_MATCH, PS_RUN} ghp_ps_t;

    function automatic logic [15:0] wake_thresh(input logic [1:0] sel, input logic rng);
        unique case ({sel, rng})
            3'b010:         wake_thresh = WAKE_1V0_UV;
            3'b011, 3'b100: wake_thresh = WAKE_2V2_UV;
            3'b101, 3'b110: wake_thresh = WAKE_4V6_UV;
            3'b111:         wake_thresh = WAKE_9V8_UV;
            default:        wake_thresh = 16'hFFFF;
        endcase
    endfunction : wake_thresh

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        mag16 = v[15] ? 16'(-v) : 16'(v);
    endfunction : mag16

    function automatic logic [15:0] diff16(input logic [15:0] a, input logic [15:0] b);
        diff16 = (a >= b) ? 16'(a - b) : 16'(b - a);
    endfunction : diff16

    // Reset counting and RAM checksum
    logic [7:0]    ram_q [RAM_WORDS];
    logic [7:0]    csum_q, scan_sum_q;
    logic [AW-1:0] scan_idx_q;
    ghp_cs_t       cs_q;
    logic [7:0]    cnt_partial_q, cnt_full_q;
    logic          wipe;
    logic          scan_last;

    assign scan_last = (scan_idx_q == AW'(RAM_WORDS - 1));
    assign wipe      = (cs_q == CS_CHECK) && (scan_sum_q != csum_q);
    assign ram_busy  = (cs_q != CS_IDLE);
    assign ram_rdata = ram_q[ram_addr];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_q          <= CS_IDLE;
            scan_idx_q    <= '0;
            scan_sum_q    <= 8'h00;
            cnt_partial_q <= 8'h00;
            cnt_full_q    <= 8'h00;
        end else begin
            unique case (cs_q)
                CS_IDLE: if (sw_reset_req) begin
                    if (sw_reset_partial) begin
                        cs_q       <= CS_SCAN;
                        scan_idx_q <= '0;
                        scan_sum_q <= 8'h00;
                    end else begin
                        cnt_full_q <= cnt_full_q + 8'h01;
                    end
                end
                CS_SCAN: begin
                    scan_sum_q <= scan_sum_q + ram_q[scan_idx_q];
                    scan_idx_q <= scan_idx_q + AW'(1);
                    if (scan_last) cs_q <= CS_CHECK;
                end
                CS_CHECK: begin
                    cs_q <= CS_IDLE;
                    // A failed check is counted as the full reset it became
                    if (wipe) cnt_full_q <= cnt_full_q + 8'h01;
                    else cnt_partial_q <= cnt_partial_q + 8'h01;
                end
                default: cs_q <= CS_IDLE;
            endcase
        end
    end

    generate
        for (genvar i = 0; i < RAM_WORDS; i++) begin : g_ram
            logic hit;
            assign hit = (ram_addr == AW'(i)) && !ram_busy;
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) ram_q[i] <= 8'h00;
                else if (wipe) ram_q[i] <= 8'h00;
                else if (hit && ram_wr) ram_q[i] <= ram_wdata;
                else if (hit && ram_upset) ram_q[i] <= ram_q[i] ^ 8'h01;
            end
        end
    endgenerate

    // Running sum keeps the stored value current without a rescan
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) csum_q <= 8'h00;
        else if (wipe) csum_q <= 8'h00;
        else if (ram_wr && !ram_busy) csum_q <= csum_q - ram_q[ram_addr] + ram_wdata;
    end

    // Sleep entry and wake comparator
    logic [15:0] avg_mag, vsr_mag, thr;
    logic        sleep_ok, wake_en, over_q, over;

    assign avg_mag  = mag16(meas.average_current_value);
    assign sleep_ok = cfg.sleep_en && (avg_mag < cfg.sleep_ma);
    assign wake_en  = cfg.sense_sel_hi | cfg.sense_sel_lo;
    assign thr      = wake_thresh({cfg.sense_sel_hi, cfg.sense_sel_lo}, cfg.wake_range_bit);
    assign vsr_mag  = mag16(meas.vsr_uv);
    assign over     = wake_en && (vsr_mag >= thr);
    assign wake_event = over && !over_q && (sleep_active || hibernate_in);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_active <= 1'b0;
            over_q       <= 1'b0;
        end else begin
            over_q       <= over;
            sleep_active <= sleep_ok && !wake_event;
        end
    end

    // Flash write gate
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_wr_go      <= 1'b0;
            flash_wr_refused <= 1'b0;
        end else begin
            flash_wr_go      <= flash_wr_req && (meas.cell_mv >= cfg.flash_min_mv);
            flash_wr_refused <= flash_wr_req && (meas.cell_mv < cfg.flash_min_mv);
        end
    end

    // Offset calibration
    logic               sleep_entry, temp_ok, drift_v, drift_t, single_cal, abort;
    logic [31:0]        cal_cnt_q;
    logic [32:0]        tdw_cnt_q;
    logic [15:0]        v_start_q, v_ref_q;
    logic signed [15:0] t_ref_q, offset_q, tdelta;

    assign sleep_entry = sleep_ok && !sleep_active;
    assign temp_ok     = (meas.temp_c > CAL_TEMP_LO_C) && (meas.temp_c < CAL_TEMP_HI_C);
    assign tdelta      = 16'(meas.temp_c - t_ref_q);
    assign drift_v     = diff16(meas.cell_mv, v_ref_q) >= CAL_VSTEP_MV;
    assign drift_t     = tdw_cnt_q >= TDWELL_CYC;
    assign single_cal  = (avg_mag <= CAL_CUR_MA) && (drift_v || drift_t);
    assign abort       = cal_busy &&
                         (32'(meas.cell_mv) + 32'(CAL_ABORT_MV) < 32'(v_start_q));
    assign vsr_corr_uv = 16'(meas.vsr_uv - offset_q);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) tdw_cnt_q <= '0;
        else if (cal_busy || mag16(tdelta) <= 16'(CAL_TSTEP_C)) tdw_cnt_q <= '0;
        else if (!drift_t) tdw_cnt_q <= tdw_cnt_q + 33'd1;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_busy        <= 1'b0;
            cal_cnt_q       <= 32'h0000_0000;
            v_start_q       <= 16'h0000;
            v_ref_q         <= 16'h0000;
            t_ref_q         <= 16'sh0000;
            offset_q        <= 16'sh0000;
            current_hold_ma <= 16'sh0000;
        end else begin
            // Rate frozen while the converter is busy with its own offset
            if (!cal_busy) current_hold_ma <= meas.average_current_value;
            if (!cal_busy && ((sleep_entry && temp_ok) || single_cal)) begin
                cal_busy  <= 1'b1;
                cal_cnt_q <= 32'h0000_0000;
                v_start_q <= meas.cell_mv;
            end else if (abort) begin
                cal_busy <= 1'b0;
            end else if (cal_busy) begin
                cal_cnt_q <= cal_cnt_q + 32'h0000_0001;
                if (cal_cnt_q >= CAL_CYC - 32'h0000_0001) begin
                    cal_busy <= 1'b0;
                    offset_q <= cal_offset_uv;
                    v_ref_q  <= meas.cell_mv;
                    t_ref_q  <= meas.temp_c;
                end
            end
        end
    end

    // Battery good and profile selection
    logic        present_m_q, present_q;
    ghp_ps_t     ps_q;
    logic [15:0] dyn_z_q [2];
    logic [1:0]  dyn_valid_q;
    logic        last_q, unsup_q, sel_lock_q, def_sel_q;
    logic [15:0] def_z, z_calc;
    logic [31:0] z_num;
    logic        match0, match1;

    assign def_z  = def_sel_q ? def_z1_mohm : def_z0_mohm;
    assign z_num  = (meas.cell_mv < ocv_mv) ? 32'(ocv_mv - meas.cell_mv) * 32'(Z_MILLI) : '0;
    assign z_calc = (avg_mag == 16'h0000) ? 16'hFFFF : 16'(z_num / 32'(avg_mag));
    assign match0 = dyn_valid_q[0] && diff16(z_calc, dyn_z_q[0]) <= Z_TOL_MOHM;
    assign match1 = dyn_valid_q[1] && diff16(z_calc, dyn_z_q[1]) <= Z_TOL_MOHM;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            present_m_q <= 1'b0;
            present_q   <= 1'b0;
            sel_lock_q  <= 1'b0;
            def_sel_q   <= 1'b0;
        end else begin
            present_m_q <= batt_present_pin;
            present_q   <= present_m_q;
            // Single variant: selection caught once after reset
            if (!sel_lock_q || (!SINGLE_PROFILE && ps_q == PS_ABSENT)) def_sel_q <= def_sel;
            sel_lock_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ps_q             <= PS_ABSENT;
            battery_good_out <= 1'b0;
            dyn_z_q[0]       <= 16'h0000;
            dyn_z_q[1]       <= 16'h0000;
            dyn_valid_q      <= 2'b00;
            last_q           <= 1'b0;
            unsup_q          <= 1'b0;
            profile_copy     <= 1'b0;
            meas_z_mohm      <= 16'h0000;
        end else begin
            profile_copy <= 1'b0;
            unique case (ps_q)
                PS_ABSENT: if (present_q) ps_q <= PS_OCV;
                PS_OCV: if (ocv_soc_done) begin
                    battery_good_out <= 1'b1;
                    ps_q             <= PS_MATCH;
                end
                PS_MATCH: begin
                    meas_z_mohm <= z_calc;
                    unsup_q     <= unsup_detect;
                    ps_q        <= PS_RUN;
                    if (dyn_valid_q == 2'b00) begin
                        profile_copy <= 1'b1;
                        last_q       <= 1'b0;
                        dyn_z_q[0]   <= def_z;
                        dyn_valid_q[0] <= 1'b1;
                        if (SINGLE_PROFILE) begin
                            dyn_z_q[1]     <= def_z;
                            dyn_valid_q[1] <= 1'b1;
                        end
                    end else if (match0) begin
                        last_q <= 1'b0;
                    end else if (match1) begin
                        last_q <= 1'b1;
                    end else begin
                        // Oldest slot is the one not used last
                        profile_copy        <= 1'b1;
                        dyn_z_q[!last_q]     <= def_z;
                        dyn_valid_q[!last_q] <= 1'b1;
                        last_q              <= !last_q;
                    end
                end
                PS_RUN: begin
                    if (z_update_valid) dyn_z_q[last_q] <= z_update_mohm;
                    if (!present_q) begin
                        battery_good_out <= 1'b0;
                        ps_q             <= PS_ABSENT;
                    end
                end
            endcase
        end
    end

    // Command read port
    logic [7:0] status_byte;

    always_comb begin
        status_byte = STATUS_RESET;
        status_byte[STAT_UNSUP_BIT] = unsup_q;
        status_byte[STAT_LU_BIT]    = last_q;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_data <= 16'h0000;
            cmd_ack  <= 1'b0;
        end else begin
            cmd_ack <= cmd_valid && (cmd_code == CMD_STATUS || cmd_code == CMD_RESET_DATA);
            if (cmd_valid && cmd_code == CMD_STATUS) cmd_data <= {8'h00, status_byte};
            else if (cmd_valid && cmd_code == CMD_RESET_DATA)
                cmd_data <= {cnt_full_q, cnt_partial_q};
        end
    end
endmodule : ghp_ctrl
`default_nettype wire

// ===== rtl/ghp_pkg.sv
// Package: constants and carriers for the gauge housekeeping control
package ghp_pkg;
    localparam logic [7:0]  CMD_STATUS      = 8'h6A;
    localparam logic [7:0]  CMD_RESET_DATA  = 8'h05;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam int          STAT_UNSUP_BIT  = 1;
    localparam int          STAT_LU_BIT     = 0;
    localparam logic [15:0] WAKE_1V0_UV     = 16'h03E8;
    localparam logic [15:0] WAKE_2V2_UV     = 16'h0898;
    localparam logic [15:0] WAKE_4V6_UV     = 16'h11F8;
    localparam logic [15:0] WAKE_9V8_UV     = 16'h2648;
    localparam logic signed [15:0] CAL_TEMP_LO_C  = 16'sh0005;
    localparam logic signed [15:0] CAL_TEMP_HI_C  = 16'sh002D;
    localparam logic signed [15:0] CAL_TSTEP_C    = 16'sh0008;
    localparam logic [15:0] CAL_VSTEP_MV    = 16'h0100;
    localparam logic [15:0] CAL_CUR_MA      = 16'h0064;
    localparam logic [15:0] CAL_ABORT_MV    = 16'h0020;
    localparam longint      CLK_HZ          = 100_000_000;
    localparam longint      CAL_TDWELL_S    = 60;
    localparam longint      CAL_TDWELL_CYC  = CAL_TDWELL_S * CLK_HZ;
    localparam longint      CAL_RUN_US      = 100;
    localparam longint      CAL_RUN_CYC     = CAL_RUN_US * CLK_HZ / 1_000_000;
    localparam logic [15:0] Z_MILLI         = 16'h03E8;

    typedef struct packed {
        logic        sense_sel_hi;
        logic        sense_sel_lo;
        logic        wake_range_bit;
        logic        sleep_en;
        logic [15:0] sleep_ma;
        logic [15:0] flash_min_mv;
    } ghp_cfg_t;

    typedef struct packed {
        logic [15:0]        cell_mv;
        logic signed [15:0] temp_c;
        logic signed [15:0] average_current_value;
        logic signed [15:0] vsr_uv;
    } ghp_meas_t;
endpackage : ghp_pkg

// ===== verif/ghp_ctrl_assertions.sv
// Checker: port-level properties of the housekeeping control
`timescale 1ns/10ps
`default_nettype none
module ghp_ctrl_chk
    import ghp_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire ghp_cfg_t    cfg,
    input wire ghp_meas_t   meas,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic        cmd_ack,
    input wire logic        flash_wr_req,
    input wire logic        flash_wr_go,
    input wire logic        flash_wr_refused,
    input wire logic        wake_event,
    input wire logic        ocv_soc_done,
    input wire logic        battery_good_out,
    input wire logic        ram_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic known_cmd = cmd_code == CMD_STATUS || cmd_code == CMD_RESET_DATA;
    wire logic volt_ok = meas.cell_mv >= cfg.flash_min_mv;

    property p_ack; cmd_valid && known_cmd |=> cmd_ack; endproperty
    a_ack: assert property (p_ack) else $error("command not acknowledged");
    property p_stat; cmd_valid && cmd_code == CMD_STATUS |=> cmd_data[15:2] == 14'h0000;
    endproperty
    a_stat: assert property (p_stat) else $error("status upper bits set");
    property p_go; flash_wr_req && volt_ok |=> flash_wr_go && !flash_wr_refused; endproperty
    a_go: assert property (p_go) else $error("flash write not granted");
    property p_ref; flash_wr_req && !volt_ok |=> flash_wr_refused && !flash_wr_go; endproperty
    a_ref: assert property (p_ref) else $error("flash write not refused");
    property p_woff; !cfg.sense_sel_hi && !cfg.sense_sel_lo |-> !wake_event; endproperty
    a_woff: assert property (p_woff) else $error("wake while disabled");
    property p_wlow; meas.vsr_uv < 16'sh03E8 && meas.vsr_uv > -16'sh03E8 |-> !wake_event;
    endproperty
    a_wlow: assert property (p_wlow) else $error("wake below lowest threshold");
    property p_bg; $rose(battery_good_out) |-> $past(ocv_soc_done, 1) || $past(ocv_soc_done, 2);
    endproperty
    a_bg: assert property (p_bg) else $error("battery good without OCV");
    // Scan of sixteen words must hold busy at least eight cycles
    property p_busy; $rose(ram_busy) |-> ram_busy [*8]; endproperty
    a_busy: assert property (p_busy) else $error("checksum scan too short");
endmodule : ghp_ctrl_chk
bind ghp_ctrl ghp_ctrl_chk u_chk (
    .sys_clk, .rst_b, .cfg, .meas, .cmd_valid, .cmd_code, .cmd_data, .cmd_ack,
    .flash_wr_req, .flash_wr_go, .flash_wr_refused, .wake_event, .ocv_soc_done,
    .battery_good_out, .ram_busy
);
`default_nettype wire

// ===== verif/ghp_host.sv
// Host model: command port master of the housekeeping control
`timescale 1ns/10ps
`default_nettype none
module ghp_host (
    input  wire logic        sys_clk,
    input  wire logic        cmd_ack,
    input  wire logic [15:0] cmd_data,
    output var  logic        cmd_valid,
    output var  logic [7:0]  cmd_code
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'hFF;
    end
    // Idle code is inverted so a stale value is never mistaken for a request
    task automatic xfer(input logic [7:0] code, output logic [15:0] data, output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        @(posedge sys_clk);
        repeat (3) begin
            @(negedge sys_clk);
            cmd_valid = 1'b0;
            cmd_code  = ~code;
            if (!ok && cmd_ack === 1'b1) begin
                ok   = 1'b1;
                data = cmd_data;
            end
        end
    endtask : xfer
endmodule : ghp_host
`default_nettype wire

// ===== verif/testbench.sv
// Testbench: scenarios for the housekeeping control
`timescale 1ns/10ps
`default_nettype none
module testbench
    import ghp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    ghp_cfg_t cfg;
    ghp_meas_t meas;
    logic sw_reset_req, sw_reset_partial, ram_wr, ram_upset, ram_busy, hibernate_in;
    logic [3:0] ram_addr;
    logic [7:0] ram_wdata, ram_rdata, cmd_code;
    logic sleep_active, wake_event, flash_wr_req, flash_wr_go, flash_wr_refused, cal_busy;
    logic batt_present_pin, ocv_soc_done, unsup_detect, def_sel, z_update_valid;
    logic battery_good_out, profile_copy, cmd_valid, cmd_ack;
    logic signed [15:0] cal_offset_uv, vsr_corr_uv, current_hold_ma;
    logic [15:0] ocv_mv, def_z0_mohm, def_z1_mohm, z_update_mohm, meas_z_mohm, cmd_data;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    ghp_ctrl #(.TDWELL_CYC(33'h64)) dut (
        .sys_clk, .rst_b, .cfg, .meas, .sw_reset_req, .sw_reset_partial, .ram_wr,
        .ram_upset, .ram_addr, .ram_wdata, .ram_rdata, .ram_busy, .hibernate_in,
        .sleep_active, .wake_event, .flash_wr_req, .flash_wr_go, .flash_wr_refused,
        .cal_offset_uv, .cal_busy, .vsr_corr_uv, .current_hold_ma, .batt_present_pin,
        .ocv_soc_done, .ocv_mv, .unsup_detect, .def_sel, .def_z0_mohm, .def_z1_mohm,
        .z_update_valid, .z_update_mohm, .battery_good_out, .profile_copy,
        .meas_z_mohm, .cmd_valid, .cmd_code, .cmd_data, .cmd_ack
    );
    ghp_host host (.sys_clk, .cmd_ack, .cmd_data, .cmd_valid, .cmd_code);

    always #5 sys_clk = ~sys_clk;

    task automatic summarize;
        if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error %0t: %s", $time, m);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] c, input logic [15:0] exp, input logic exp_ok);
        logic [15:0] d;
        logic ok;
        host.xfer(c, d, ok);
        chk(ok === exp_ok, "command answer");
        if (exp_ok) chk(d === exp, "command data");
    endtask : cmd

    function automatic logic [15:0] thr(input int k);
        case (k)
            2: return 16'h03E8;
            3, 4: return 16'h0898;
            5, 6: return 16'h11F8;
            7: return 16'h2648;
            default: return 16'h4E20;
        endcase
    endfunction : thr

    task automatic t_cal;
        int i;
        for (i = 0; i < 300 && cal_busy !== 1'b1; i++) @(negedge sys_clk);
        chk(cal_busy === 1'b1, "calibration not started");
        meas.average_current_value = 16'sh003C;
        @(negedge sys_clk);
        chk(current_hold_ma === 16'sh0032, "rate not held");
        meas.cell_mv = 16'h0E10;
        for (i = 0; i < 4 && cal_busy === 1'b1; i++) @(negedge sys_clk);
        chk(cal_busy === 1'b0, "calibration not aborted");
        meas.average_current_value = 16'sh00C8;
    endtask : t_cal

    task automatic flash(input logic [15:0] mv, input logic go);
        @(negedge sys_clk);
        meas.cell_mv = mv;
        flash_wr_req = 1'b1;
        @(negedge sys_clk);
        flash_wr_req = 1'b0;
        chk(flash_wr_go === go && flash_wr_refused === !go, "flash gate");
    endtask : flash

    task automatic t_wake;
        logic signed [15:0] v;
        int k;
        hibernate_in = 1'b1;
        for (k = 0; k < 8; k++) begin
            v = $signed(thr(k));
            if (k[0]) v = -v;
            {cfg.sense_sel_hi, cfg.sense_sel_lo, cfg.wake_range_bit} = k[2:0];
            meas.vsr_uv = k[0] ? v + 16'sh0001 : v - 16'sh0001;
            @(negedge sys_clk);
            chk(wake_event === 1'b0, "wake below threshold");
            meas.vsr_uv = v;
            #1;
            chk(wake_event === (k > 1), "wake at threshold");
            @(negedge sys_clk);
            meas.vsr_uv = 16'sh0000;
            @(negedge sys_clk);
        end
        hibernate_in = 1'b0;
        @(negedge sys_clk);
        meas.vsr_uv = 16'sh4E20;
        #1;
        chk(wake_event === 1'b0, "wake while awake");
        meas.vsr_uv = 16'sh0000;
    endtask : t_wake

    task automatic pulse_rst(input logic part);
        int i;
        @(negedge sys_clk);
        sw_reset_req = 1'b1;
        sw_reset_partial = part;
        @(negedge sys_clk);
        sw_reset_req = 1'b0;
        for (i = 0; i < 40 && ram_busy !== 1'b0; i++) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask : pulse_rst

    task automatic t_reset;
        pulse_rst(1'b0);
        ram_addr = 4'h3;
        ram_wdata = 8'hA5;
        ram_wr = 1'b1;
        @(negedge sys_clk);
        ram_wr = 1'b0;
        pulse_rst(1'b1);
        chk(ram_rdata === 8'hA5, "RAM lost");
        cmd(CMD_RESET_DATA, 16'h0101, 1'b1);
        ram_upset = 1'b1;
        @(negedge sys_clk);
        ram_upset = 1'b0;
        pulse_rst(1'b1);
        chk(ram_rdata === 8'h00, "RAM not wiped");
        cmd(CMD_RESET_DATA, 16'h0201, 1'b1);
    endtask : t_reset

    task automatic insert(input logic [15:0] mv, input logic [15:0] z, input logic [15:0] st,
                          input logic cp);
        int i;
        @(negedge sys_clk);
        batt_present_pin = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk(battery_good_out === 1'b0, "good while absent");
        meas.cell_mv = mv;
        batt_present_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk(battery_good_out === 1'b0, "good before OCV");
        ocv_soc_done = 1'b1;
        @(negedge sys_clk);
        ocv_soc_done = 1'b0;
        for (i = 0; i < 5 && battery_good_out !== 1'b1; i++) @(negedge sys_clk);
        chk(battery_good_out === 1'b1, "good after OCV");
        @(negedge sys_clk);
        chk(profile_copy === cp, "profile copy");
        repeat (3) @(negedge sys_clk);
        chk(meas_z_mohm === z, "impedance");
        cmd(CMD_STATUS, st, 1'b1);
    endtask : insert

    task automatic t_sleep;
        int i;
        cal_offset_uv = 16'sh0010;
        meas.vsr_uv = 16'sh0100;
        cfg.sleep_ma = 16'h0100;
        cfg.sleep_en = 1'b1;
        @(negedge sys_clk);
        chk(sleep_active === 1'b1 && cal_busy === 1'b1, "no sleep calibration");
        for (i = 0; i < 10005 && cal_busy === 1'b1; i++) @(negedge sys_clk);
        chk(vsr_corr_uv === 16'sh00F0 && cal_busy === 1'b0, "offset not applied");
        meas.average_current_value = 16'sh012C;
        @(negedge sys_clk);
        chk(sleep_active === 1'b0, "sleep kept");
    endtask : t_sleep

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 12000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        cfg = '0;
        cfg.flash_min_mv = 16'h0BB8;
        meas = '0;
        meas.cell_mv = 16'h0E74;
        meas.temp_c = 16'sh0019;
        meas.average_current_value = 16'sh0032;
        {sw_reset_req, sw_reset_partial, ram_wr, ram_upset, hibernate_in} = '0;
        {flash_wr_req, batt_present_pin, ocv_soc_done, unsup_detect} = '0;
        {def_sel, z_update_valid, ram_addr, ram_wdata} = '0;
        cal_offset_uv = 16'sh0000;
        z_update_mohm = 16'h0000;
        ocv_mv = 16'h0ED8;
        def_z0_mohm = 16'h03E8;
        def_z1_mohm = 16'h03E8;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        cmd(CMD_STATUS, STATUS_RESET, 1'b1);
        cmd(8'h33, 16'h0000, 1'b0);
        t_cal();
        flash(16'h0BB7, 1'b0);
        flash(16'h0BB8, 1'b1);
        t_wake();
        t_reset();
        insert(16'h0E10, 16'h03E8, 16'h0000, 1'b1);
        unsup_detect = 1'b1;
        insert(16'h0D48, 16'h07D0, 16'h0003, 1'b1);
        unsup_detect = 1'b0;
        insert(16'h0E10, 16'h03E8, 16'h0000, 1'b0);
        t_sleep();
        summarize();
    end
endmodule : testbench
`default_nettype wire
